// ===== hdl/lpr_pkg.sv
// lpr_pkg: constants, types and register layout of the lookup / pipe delay /
// ripple counter macrocell.
// assumes: used only through lpr_pkg::name, never imported.
package lpr_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned DW = 32;
	localparam int unsigned AW = 32;
	localparam int unsigned STAGES = 16;
	localparam int unsigned CW = 3;

	// ------------------------------------------------------------------
	// register byte offsets, cfg reset value and write mask
	// ------------------------------------------------------------------
	localparam logic [11:0] CFG_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK = 32'h0003_FFFF;

	// ------------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------------
	localparam int unsigned TT_LSB = 0; // truth table, 8 bits
	localparam int unsigned SEL_A_LSB = 0; // tap a depth - 1, 4 bits
	localparam int unsigned SEL_B_LSB = 4; // tap b depth - 1, 4 bits
	localparam int unsigned INV_B_BIT = 8;
	localparam int unsigned FUNC_LSB = 9; // 2 bits
	localparam int unsigned PRESET_LSB = 11;
	localparam int unsigned END_LSB = 14;
	localparam int unsigned FULL_BIT = 17;

	// ------------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------------
	localparam int unsigned ST_LUT_BIT = 0;
	localparam int unsigned ST_TAPA_BIT = 1;
	localparam int unsigned ST_TAPB_BIT = 2;
	localparam int unsigned ST_CNT_LSB = 3;
	localparam int unsigned ST_PIPE_LSB = 6;

	// ------------------------------------------------------------------
	// ahb encodings
	// ------------------------------------------------------------------
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [DW-1:0] RDATA_ZERO = 32'h0000_0000;

	// active function of the cell
	typedef enum logic [1:0] {
		LPR_FN_LUT = 2'b00,
		LPR_FN_PIPE = 2'b01,
		LPR_FN_RIPPLE = 2'b10,
		LPR_FN_OFF = 2'b11
	} lpr_func_t;

	// matrix inputs, carried together through the synchroniser
	typedef struct packed {
		logic [2:0] lut_in;
		logic data;
		logic mclk;
		logic stage_clear_n;
		logic preset_load_n;
		logic count_up;
	} lpr_mtx_t;

	localparam lpr_mtx_t MTX_RST = '{3'b000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

endpackage

// ===== hdl/lpr_cell.sv
// lpr_cell: configurable macrocell, lookup table or pipe delay or ripple
// counter, with its configuration reached over an ahb-lite slave.
// assumes: matrix inputs are asynchronous to clk_i; the matrix clock is
// slower than clk_i / 4 so each edge is seen after synchronising.
//
// Functional notes
// - configuration selects at most one function: lookup, pipe or counter, or none when off.
// - lookup output is the truth table bit indexed by {in2,in1,in0}.
// - gate encodings and, nand, or, nor, xor, xnor are truth table values.
// - pipe delay is sixteen flip-flops in series fed by the data input.
// - tap a depth and tap b depth each pick 1 to 16 stages by 4-bit fields.
// - each stage delays by one period of the matrix clock.
// - tap b is inverted when its invert bit is set, tap a never.
// - while preset load is low the counter outputs show the preset value.
// - counting up, after the end value the next clock edge returns to the first code.
// - range mode counting down follows the preset/end ordering sequence.
// - range mode counting up goes preset to end and repeats.
// - full mode down counts to zero, then end value down to zero again.
// - full mode up counts from preset, wraps to zero, then zero to end.
// - counter steps only on a rising edge of the matrix clock.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module lpr_cell (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// matrix inputs
	input wire logic [2:0] lut_in_i,
	input wire logic mtx_data_i,
	input wire logic mtx_clk_i,
	input wire logic stage_clear_n_i,
	input wire logic preset_load_n_i,
	input wire logic count_up_i,
	// matrix outputs
	output logic lut_out_o,
	output logic tap_out_a_o,
	output logic tap_out_b_o,
	output logic [2:0] count_o
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// next code of the ripple counter for one clock step
	function automatic logic [2:0] cnt_step(input logic [2:0] cur,
		input logic [2:0] pre, input logic [2:0] fin, input logic full,
		input logic up);
		logic [2:0] res;
		res = cur;
		if (full) begin
			if (up) begin
				res = (cur == fin) ? 3'h0 : cur + 3'h1;
			end else begin
				res = (cur == 3'h0) ? fin : cur - 3'h1;
			end
		end else if (up) begin
			res = (cur == fin) ? pre : cur + 3'h1;
		end else if (pre < fin && cur == pre) begin
			res = fin;
		end else if (pre > fin && cur == fin) begin
			res = pre;
		end else if (pre != fin) begin
			res = cur - 3'h1;
		end
		return res;
	endfunction

	// register address match on the low word offset
	function automatic logic ofs_hit(input logic [31:0] a,
		input logic [11:0] ofs);
		return (a[11:2] == ofs[11:2]) && (a[31:12] == 20'h0_0000);
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	lpr_pkg::lpr_mtx_t mtx_raw;
	lpr_pkg::lpr_mtx_t sync1_r, sync1_nxt;
	lpr_pkg::lpr_mtx_t sync2_r, sync2_nxt;
	logic mclk_prev_r, mclk_prev_nxt;
	logic mclk_rise;

	logic [31:0] cfg_r, cfg_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [31:0] status;
	logic addr_ok;

	lpr_pkg::lpr_func_t func;
	logic [7:0] truth;
	logic [3:0] sel_a, sel_b;
	logic inv_b, full_mode;
	logic [2:0] preset_val, end_value;

	logic [lpr_pkg::STAGES-1:0] pipe_r, pipe_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic lut_r, lut_nxt;
	logic tap_a_r, tap_a_nxt;
	logic tap_b_r, tap_b_nxt;

	// ------------------------------------------------------------------
	// matrix input synchroniser
	// ------------------------------------------------------------------

	// pack pins; every one crosses two flops before any logic sees it
	always_comb begin
		mtx_raw = '{lut_in_i, mtx_data_i, mtx_clk_i, stage_clear_n_i,
			preset_load_n_i, count_up_i};
		sync1_nxt = mtx_raw;
		sync2_nxt = sync1_r;
		mclk_prev_nxt = sync2_r.mclk;
	end

	// stage one feeds stage two only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_r <= lpr_pkg::MTX_RST;
			sync2_r <= lpr_pkg::MTX_RST;
			mclk_prev_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			mclk_prev_r <= mclk_prev_nxt;
		end
	end

	// edge taken from the second stage, a third flop gives the history
	assign mclk_rise = sync2_r.mclk & ~mclk_prev_r;

	// ------------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------------

	// truth table bits double as tap depth selects, as in the cell
	always_comb begin
		func = lpr_pkg::lpr_func_t'(cfg_r[lpr_pkg::FUNC_LSB +: 2]);
		truth = cfg_r[lpr_pkg::TT_LSB +: 8];
		sel_a = cfg_r[lpr_pkg::SEL_A_LSB +: 4];
		sel_b = cfg_r[lpr_pkg::SEL_B_LSB +: 4];
		inv_b = cfg_r[lpr_pkg::INV_B_BIT];
		preset_val = cfg_r[lpr_pkg::PRESET_LSB +: 3];
		end_value = cfg_r[lpr_pkg::END_LSB +: 3];
		full_mode = cfg_r[lpr_pkg::FULL_BIT];
	end

	// ------------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------------

	// zero wait states: reads are sampled in the address phase so the
	// data phase is one cycle; a read right after a write sees old cfg
	always_comb begin
		addr_ok = hsel_i && htrans_i[1] && hready_i;
		wr_pend_nxt = 1'b0;
		hrdata_nxt = hrdata_r;
		cfg_nxt = cfg_r;
		if (wr_pend_r) begin
			cfg_nxt = hwdata_i & lpr_pkg::CFG_WMASK;
		end
		if (addr_ok) begin
			wr_pend_nxt = hwrite_i && ofs_hit(haddr_i, lpr_pkg::CFG_OFS);
			if (hwrite_i) begin
				hrdata_nxt = lpr_pkg::RDATA_ZERO;
			end else if (ofs_hit(haddr_i, lpr_pkg::CFG_OFS)) begin
				hrdata_nxt = cfg_r;
			end else if (ofs_hit(haddr_i, lpr_pkg::STAT_OFS)) begin
				hrdata_nxt = status;
			end else begin
				hrdata_nxt = lpr_pkg::RDATA_ZERO; // unmapped reads zero
			end
		end
	end

	// bus state registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_r <= lpr_pkg::CFG_RST;
			wr_pend_r <= 1'b0;
			hrdata_r <= lpr_pkg::RDATA_ZERO;
		end else begin
			cfg_r <= cfg_nxt;
			wr_pend_r <= wr_pend_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	assign hrdata_o = hrdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o = lpr_pkg::HRESP_OKAY;

	// live state of the cell for software
	always_comb begin
		status = '0;
		status[lpr_pkg::ST_LUT_BIT] = lut_r;
		status[lpr_pkg::ST_TAPA_BIT] = tap_a_r;
		status[lpr_pkg::ST_TAPB_BIT] = tap_b_r;
		status[lpr_pkg::ST_CNT_LSB +: 3] = cnt_r;
		status[lpr_pkg::ST_PIPE_LSB +: lpr_pkg::STAGES] = pipe_r;
	end

	// ------------------------------------------------------------------
	// cell core
	// ------------------------------------------------------------------

	// inactive functions are held at zero so only one drives outputs
	always_comb begin
		pipe_nxt = pipe_r;
		cnt_nxt = cnt_r;
		if (func != lpr_pkg::LPR_FN_PIPE) begin
			pipe_nxt = '0;
		end else if (!sync2_r.stage_clear_n) begin
			pipe_nxt = '0;
		end else if (mclk_rise) begin
			pipe_nxt = {pipe_r[lpr_pkg::STAGES-2:0], sync2_r.data};
		end
		if (func != lpr_pkg::LPR_FN_RIPPLE) begin
			cnt_nxt = '0;
		end else if (!sync2_r.preset_load_n) begin
			cnt_nxt = preset_val;
		end else if (mclk_rise) begin
			cnt_nxt = cnt_step(cnt_r, preset_val, end_value, full_mode,
				sync2_r.count_up);
		end
		lut_nxt = (func == lpr_pkg::LPR_FN_LUT) &&
			truth[sync2_r.lut_in];
		tap_a_nxt = (func == lpr_pkg::LPR_FN_PIPE) && pipe_r[sel_a];
		tap_b_nxt = (func == lpr_pkg::LPR_FN_PIPE) &&
			(pipe_r[sel_b] ^ inv_b);
	end

	// core and output registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pipe_r <= '0;
			cnt_r <= '0;
			lut_r <= 1'b0;
			tap_a_r <= 1'b0;
			tap_b_r <= 1'b0;
		end else begin
			pipe_r <= pipe_nxt;
			cnt_r <= cnt_nxt;
			lut_r <= lut_nxt;
			tap_a_r <= tap_a_nxt;
			tap_b_r <= tap_b_nxt;
		end
	end

	assign lut_out_o = lut_r;
	assign tap_out_a_o = tap_a_r;
	assign tap_out_b_o = tap_b_r;
	assign count_o = cnt_r;

endmodule // lpr_cell

// ===== bench/lpr_mtx_model.sv
// matrix side model: one matrix clock pulse per request
// assumes: clk_i is the cell's system clock
`timescale 1ns/1ps
module lpr_mtx_model (
	// control
	input wire logic clk_i,
	input wire logic go_i,
	// matrix clock
	output logic mclk_o,
	output logic busy_o
);
	// ----
	// pulse
	// ----
	logic [2:0] ph_r = 3'h0;
	logic [2:0] ph_nxt;
	// high three, low five: both long enough for the two sync flops
	always_comb begin
		ph_nxt = (ph_r != 3'h0 || go_i) ? ph_r + 3'h1 : ph_r;
	end
	always_ff @(posedge clk_i) begin
		ph_r <= ph_nxt;
	end
	// clock stands low between requests
	assign mclk_o = ph_r inside {3'h1, 3'h2, 3'h3};
	assign busy_o = ph_r != 3'h0;
endmodule // lpr_mtx_model

// ===== bench/lpr_cell_sva.sv
// checker: bus answers and matrix-side quiet periods of the cell
// assumes: bound into lpr_cell, one clock domain
`timescale 1ns/1ps
module lpr_cell_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// matrix
	input wire logic [2:0] lut_in_i,
	input wire logic mtx_clk_i,
	input wire logic stage_clear_n_i,
	input wire logic preset_load_n_i,
	input wire logic lut_out_o,
	input wire logic tap_out_a_o,
	input wire logic [2:0] count_o
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take; hsel_i && htrans_i[1] && hready_i; endsequence
	// five low samples cover two sync flops, the stages and the tap flop
	sequence s_clr; !stage_clear_n_i [*5]; endsequence
	property p_rdy; hreadyout_o && !hresp_o; endproperty
	a_rdy: assert property (p_rdy) else $error("bus not ready or okay");
	property p_wr0; s_take ##0 hwrite_i |=> hrdata_o == 32'h0000_0000;
	endproperty
	a_wr0: assert property (p_wr0) else $error("write data phase not 0");
	property p_unm; s_take ##0 (!hwrite_i && haddr_i[31:3] != 29'h0000_0000)
		|=> hrdata_o == 32'h0000_0000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not 0");
	property p_hold; !(hsel_i && htrans_i[1] && hready_i) |=> $stable(hrdata_o);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_clr; s_clr |-> !tap_out_a_o; endproperty
	a_clr: assert property (p_clr) else $error("tap a not cleared");
	property p_pipe; (!mtx_clk_i && !hsel_i && stage_clear_n_i) [*6]
		|-> $stable(tap_out_a_o); endproperty
	a_pipe: assert property (p_pipe) else $error("tap moved unclocked");
	property p_cnt; (!mtx_clk_i && !hsel_i && preset_load_n_i) [*6]
		|-> $stable(count_o); endproperty
	a_cnt: assert property (p_cnt) else $error("count moved unclocked");
	property p_pre; (!preset_load_n_i && !hsel_i) [*6] |-> $stable(count_o);
	endproperty
	a_pre: assert property (p_pre) else $error("count moved in load");
	property p_lut; ($stable(lut_in_i) && !hsel_i) [*6] |-> $stable(lut_out_o);
	endproperty
	a_lut: assert property (p_lut) else $error("lut out moved");
endmodule // lpr_cell_sva
bind lpr_cell lpr_cell_sva i_sva (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
	.htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
	.lut_in_i, .mtx_clk_i, .stage_clear_n_i, .preset_load_n_i, .lut_out_o,
	.tap_out_a_o, .count_o);

// ===== bench/test_lut_pipe_delay_ripple_counter.sv
// bench: cell driven over ahb-lite, matrix clocks from the model
// assumes: lpr_pkg compiled first, checker bound to the cell
`timescale 1ns/1ps
module test_lut_pipe_delay_ripple_counter;
	// ----
	// nets and tasks
	// ----
	logic clk_i, rst_n_i, hsel, hwrite, hready, hresp, go, busy, mclk;
	logic lut_out, ta, tb;
	logic [1:0] htrans;
	logic [2:0] hsize, cnt, pv, ev, c;
	logic [31:0] haddr, hwdata, hrdata, q;
	lpr_pkg::lpr_mtx_t mx;
	logic [7:0] tt [6] = '{8'h80, 8'h7F, 8'hFE, 8'h01, 8'h96, 8'h69};
	logic [31:0] pc [2] = '{32'h0000_03F0, 32'h0000_020F};
	int n_fail = 0;
	int cmp_count = 0;
	lpr_cell i_dut (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .lut_in_i(mx.lut_in),
		.mtx_data_i(mx.data), .mtx_clk_i(mclk),
		.stage_clear_n_i(mx.stage_clear_n),
		.preset_load_n_i(mx.preset_load_n), .count_up_i(mx.count_up),
		.lut_out_o(lut_out), .tap_out_a_o(ta), .tap_out_b_o(tb),
		.count_o(cnt));
	lpr_mtx_model i_mtx (.clk_i, .go_i(go), .mclk_o(mclk), .busy_o(busy));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// bounded wait for hready at an edge; a dead bus ends the run
	task automatic rdy;
		int k;
		k = 0;
		@(posedge clk_i);
		while (hready !== 1'b1) begin
			k++;
			if (k > 20) begin
				n_fail++;
				close_out;
			end
			@(posedge clk_i);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, e, input string nm);
		ahb(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask
	// one matrix clock; busy is looked at on the falling edge, where it
	// has settled, and a pulse that never ends counts as a mismatch
	task automatic tick;
		int k;
		k = 0;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(negedge clk_i);
		while (busy === 1'b1 && k < 12) begin
			k++;
			@(negedge clk_i);
		end
		if (busy !== 1'b0) begin
			chk("model busy", 32'h0000_0000, 32'(busy));
			close_out;
		end
		@(posedge clk_i);
	endtask
	// next code of the counter, worked out from preset, end and mode
	function automatic logic [2:0] nxt(input logic [2:0] c, p, e,
		input logic full, up);
		if (full) begin
			return up ? (c == e ? 3'h0 : c + 3'h1)
				: (c == 3'h0 ? e : c - 3'h1);
		end
		if (up) begin
			return c == e ? p : c + 3'h1;
		end
		return (p < e ? c == p : c == e) ? (p < e ? e : p) : c - 3'h1;
	endfunction
	initial begin
		rst_n_i = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		go = 1'b0;
		mx = lpr_pkg::MTX_RST;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(32'h0000_0000, lpr_pkg::CFG_RST, "cfg reset");
		ahb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(32'h0000_0000, lpr_pkg::CFG_WMASK, "cfg mask");
		rd(32'h0000_0040, 32'h0000_0000, "unmapped");
		$display("test regs done");
		foreach (tt[g]) begin
			ahb(1'b1, 32'h0000_0000, {24'h00_0000, tt[g]});
			for (int i = 0; i < 8; i++) begin
				mx.lut_in <= i[2:0];
				repeat (8) @(posedge clk_i);
				chk("lut out", 32'(tt[g][i]), 32'(lut_out));
			end
		end
		$display("test lut done");
		foreach (pc[p]) begin
			ahb(1'b1, 32'h0000_0000, pc[p]);
			mx.stage_clear_n <= 1'b0;
			repeat (6) @(posedge clk_i);
			mx.stage_clear_n <= 1'b1;
			mx.data <= 1'b1;
			tick;
			mx.data <= 1'b0;
			for (int k = 1; k < 18; k++) begin
				chk("tap a", 32'(k == int'(pc[p][3:0]) + 1), 32'(ta));
				chk("tap b", 32'((k == int'(pc[p][7:4]) + 1) ^ pc[p][8]),
					32'(tb));
				tick;
			end
		end
		mx.data <= 1'b1;
		repeat (16) tick;
		rd(32'h0000_0004, 32'h003F_FFC6, "stages full");
		mx.stage_clear_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		rd(32'h0000_0004, 32'h0000_0000, "stages clear");
		mx.stage_clear_n <= 1'b1;
		$display("test pipe done");
		for (int m = 0; m < 8; m++) begin
			pv = m[0] ? 3'h5 : 3'h2;
			ev = 3'h7 - pv;
			mx.count_up <= m[1];
			ahb(1'b1, 32'h0000_0000, {14'h0000, m[2], ev, pv, 11'h400});
			mx.preset_load_n <= 1'b0;
			tick;
			chk("preset", 32'(pv), 32'(cnt));
			mx.preset_load_n <= 1'b1;
			repeat (4) @(posedge clk_i);
			c = pv;
			for (int s = 0; s < 10; s++) begin
				tick;
				c = nxt(c, pv, ev, m[2], m[1]);
				chk("count", 32'(c), 32'(cnt));
			end
		end
		// switched off with a count standing: every output and stage drops
		ahb(1'b1, 32'h0000_0000, 32'h0000_06FF);
		repeat (4) @(posedge clk_i);
		rd(32'h0000_0004, 32'h0000_0000, "func off");
		$display("test counter done");
		close_out;
	end
endmodule // test_lut_pipe_delay_ripple_counter
